// file: temp_limit_compare.sv
`default_nettype none
// Notes on behaviour
// R1: Below-window bit 13 sets under lower minus hysteresis, clears at lower; above-window bit 14 sets over upper, clears at upper minus hysteresis.
// R2: Above-critical bit 15 sets at critical, clears below critical minus hysteresis.
// R3: Temperatures and limits are 13-bit two's complement with sign bit 12, one count is 1/16 degree.
// R4: Measured temperature has eighth-degree steps; bit 0 always reads zero.
// R5: Temperature bit 11 weighs 128 degrees, halving downward to eighth-degree.
// R6: Top three bits hold trip flags from temperature only, not alert state.
// R7: Upper limit keeps sign bit 12 and bits 11:2; other bits read zero.
// R8: Lower limit keeps sign bit 12 and bits 11:2; bits 15:13, 1:0 zero.
// R9: Comparisons always use currently programmed limits; no commit step.
// R10: Host should mask alerts while changing limits in a running system.
// R11: Window lock bit blocks upper/lower writes; only reset clears it.
// R12: Critical limit keeps sign bit 12 and bits 11:2; rest reads zero.
// R13: All three flags re-evaluated on each new result, using stored flag state.
// R14: Upper and lower limits reset to zero.
module temp_limit_compare (
	input  wire logic        ref_clk,
	input  wire logic        srst,
	input  wire logic        convValid,
	input  wire logic [11:0] convSample,
	input  wire logic [12:0] hystAmount,
	input  wire logic [7:0]  regAddr,
	input  wire logic        regWrite,
	input  wire logic [15:0] regWdata,
	output logic      [15:0] regRdata,
	output logic      [15:0] tempWord,
	output logic             windowLock
);
	// ----------------------------------------
	// Limit storage
	// ----------------------------------------
	limit_reg_if lim ();

	limit_reg_bank limit_reg_bank_i (
		.ref_clk (ref_clk),
		.srst    (srst),
		.lim     (lim.bank)
	);

	logic windowLock_r;

	assign lim.wrEn       = regWrite;
	assign lim.wrAddr     = regAddr;
	assign lim.wrData     = regWdata;
	assign lim.windowLock = windowLock_r;

	// Lock is sticky: software can set it but never clear it
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			windowLock_r <= 1'b0; // [R11]
		end else if (regWrite && regAddr == temp_limit_pkg::PTR_CONFIG
			&& regWdata[temp_limit_pkg::WINDOW_LOCK_POS]) begin
			windowLock_r <= 1'b1; // [R11]
		end
	end

	assign windowLock = windowLock_r;

	// ----------------------------------------
	// Comparison arithmetic
	// ----------------------------------------
	// Fifteen bits so a limit minus the largest hysteresis cannot wrap
	function automatic logic signed [14:0] limExt(input logic [15:0] v);
		limExt = {{2{v[temp_limit_pkg::SIGN_POS]}}, v[12:0]};
	endfunction

	logic signed [14:0] tNew;
	logic signed [14:0] hyst;
	logic signed [14:0] upperVal;
	logic signed [14:0] lowerVal;
	logic signed [14:0] critVal;
	logic signed [14:0] upperHys;
	logic signed [14:0] lowerHys;
	logic signed [14:0] critHys;

	assign tNew     = {{2{convSample[11]}}, convSample, 1'b0}; // [R3] [R5]
	assign hyst     = {2'b00, hystAmount};
	assign upperVal = limExt(lim.upperLimit); // [R9]
	assign lowerVal = limExt(lim.lowerLimit); // [R9]
	assign critVal  = limExt(lim.critLimit);  // [R9]
	assign upperHys = upperVal - hyst;
	assign lowerHys = lowerVal - hyst;
	assign critHys  = critVal - hyst;

	// ----------------------------------------
	// Trip flags with hysteresis
	// ----------------------------------------
	logic critFlag;
	logic aboveFlag;
	logic belowFlag;
	logic critFlag_nxt;
	logic aboveFlag_nxt;
	logic belowFlag_nxt;

	assign critFlag  = tempWord[temp_limit_pkg::ABOVE_CRIT_POS];
	assign aboveFlag = tempWord[temp_limit_pkg::ABOVE_WIN_POS];
	assign belowFlag = tempWord[temp_limit_pkg::BELOW_WIN_POS];

	always_comb begin
		if (critFlag) begin
			critFlag_nxt = !(tNew < critHys); // [R2] [R13]
		end else begin
			critFlag_nxt = (tNew >= critVal); // [R2]
		end
		if (aboveFlag) begin
			aboveFlag_nxt = !(tNew <= upperHys); // [R1] [R13]
		end else begin
			aboveFlag_nxt = (tNew > upperVal); // [R1]
		end
		if (belowFlag) begin
			belowFlag_nxt = !(tNew >= lowerVal); // [R1] [R13]
		end else begin
			belowFlag_nxt = (tNew < lowerHys); // [R1]
		end
	end

	// ----------------------------------------
	// Temperature word
	// ----------------------------------------
	// Flags come only from the result, so alert logic cannot disturb them
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			tempWord <= temp_limit_pkg::TEMP_RESET;
		end else if (convValid) begin
			tempWord <= {critFlag_nxt, aboveFlag_nxt, belowFlag_nxt, convSample, 1'b0}; // [R4] [R6] [R13]
		end
	end

	// ----------------------------------------
	// Register read-back
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			regRdata <= 16'h0000;
		end else begin
			unique case (regAddr)
				temp_limit_pkg::PTR_CONFIG: regRdata <= 16'(windowLock_r) << temp_limit_pkg::WINDOW_LOCK_POS;
				temp_limit_pkg::PTR_UPPER:  regRdata <= lim.upperLimit; // [R7]
				temp_limit_pkg::PTR_LOWER:  regRdata <= lim.lowerLimit; // [R8]
				temp_limit_pkg::PTR_CRIT:   regRdata <= lim.critLimit;  // [R12]
				temp_limit_pkg::PTR_TEMP:   regRdata <= tempWord;
				default:                    regRdata <= 16'h0000;
			endcase
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	sequence critRise;
		convValid && !critFlag && tNew >= critVal;
	endsequence
	sequence critFallBelow;
		convValid && critFlag && tNew < critHys;
	endsequence
	sequence critInBand;
		convValid && critFlag && tNew >= critHys;
	endsequence
	sequence aboveRise;
		convValid && !aboveFlag && tNew > upperVal;
	endsequence
	sequence aboveHold;
		convValid && aboveFlag && tNew > upperHys;
	endsequence
	sequence belowFall;
		convValid && !belowFlag && tNew < lowerHys;
	endsequence
	sequence belowRecover;
		convValid && belowFlag && tNew >= lowerVal;
	endsequence
	sequence aboveFall;
		convValid && aboveFlag && tNew <= upperHys;
	endsequence
	sequence belowInBand;
		convValid && belowFlag && tNew < lowerVal;
	endsequence
	sequence lockWrite;
		regWrite && regAddr == temp_limit_pkg::PTR_CONFIG && regWdata[temp_limit_pkg::WINDOW_LOCK_POS];
	endsequence

	AST_CRIT_SET: assert property (critRise |=> tempWord[15]) // [R2]
		else $error("critical flag not set at limit");
	AST_CRIT_CLEAR: assert property (critFallBelow |=> !tempWord[15]) // [R2]
		else $error("critical flag not cleared below hysteresis");
	AST_CRIT_HOLD: assert property (critInBand |=> tempWord[15]) // [R2] [R13]
		else $error("critical flag dropped inside hysteresis band");
	AST_ABOVE_SET: assert property (aboveRise |=> tempWord[14]) // [R1]
		else $error("above-window flag not set");
	AST_ABOVE_HOLD: assert property (aboveHold |=> tempWord[14]) // [R1] [R13]
		else $error("above-window flag dropped inside band");
	AST_BELOW_SET: assert property (belowFall |=> tempWord[13]) // [R1]
		else $error("below-window flag not set");
	AST_BELOW_CLEAR: assert property (belowRecover |=> !tempWord[13]) // [R1]
		else $error("below-window flag not cleared at lower limit");
	AST_TEMP_FIELD: assert property (convValid |=> tempWord[12:1] == $past(convSample) && !tempWord[0]) // [R4] [R5]
		else $error("temperature field misplaced");
	AST_WORD_STEADY: assert property (!convValid |=> $stable(tempWord)) // [R6] [R13]
		else $error("temperature word changed without a result");
	AST_LOCK_STICKY: assert property (windowLock_r |=> windowLock_r) // [R11]
		else $error("window lock cleared without reset");
	AST_NEW_LIMIT: assert property (regWrite && regAddr == temp_limit_pkg::PTR_UPPER && !windowLock_r // [R9]
		##1 convValid && !aboveFlag |-> aboveFlag_nxt == (tNew > limExt($past(regWdata) & temp_limit_pkg::LIMIT_MASK)))
		else $error("new upper limit not used at once");
	AST_ABOVE_CLEAR: assert property (aboveFall |=> !tempWord[14]) // [R1]
		else $error("above-window flag not cleared below hysteresis");
	AST_BELOW_HOLD: assert property (belowInBand |=> tempWord[13]) // [R1] [R13]
		else $error("below-window flag dropped inside band");
	AST_LOCK_SET: assert property (lockWrite |=> windowLock_r) // [R11]
		else $error("window lock not set by config write");

	// Read-back lags the pointer by one cycle, so compare against last cycle's source
	AST_READ_TEMP: assert property (regAddr == temp_limit_pkg::PTR_TEMP |=> regRdata == $past(tempWord)) // [R6]
		else $error("temperature word read-back wrong");
	AST_READ_UPPER: assert property (regAddr == temp_limit_pkg::PTR_UPPER |=> regRdata == $past(lim.upperLimit)) // [R7]
		else $error("upper limit read-back wrong");
	AST_READ_CRIT: assert property (regAddr == temp_limit_pkg::PTR_CRIT |=> regRdata == $past(lim.critLimit)) // [R12]
		else $error("critical limit read-back wrong");
endmodule // temp_limit_compare
`default_nettype wire

// file: temp_limit_pkg.sv
`default_nettype none
package temp_limit_pkg;
	// ----------------------------------------
	// Register pointers
	// ----------------------------------------
	localparam logic [7:0]  PTR_CONFIG      = 8'h01;
	localparam logic [7:0]  PTR_UPPER       = 8'h02;
	localparam logic [7:0]  PTR_LOWER       = 8'h03;
	localparam logic [7:0]  PTR_CRIT        = 8'h04;
	localparam logic [7:0]  PTR_TEMP        = 8'h05;

	// ----------------------------------------
	// Field layout
	// ----------------------------------------
	localparam int          WINDOW_LOCK_POS = 6;
	localparam int          ABOVE_CRIT_POS  = 15;
	localparam int          ABOVE_WIN_POS   = 14;
	localparam int          BELOW_WIN_POS   = 13;
	localparam int          SIGN_POS        = 12;
	localparam logic [15:0] LIMIT_MASK      = 16'h1FFC;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [15:0] LIMIT_RESET     = 16'h0000;
	localparam logic [15:0] TEMP_RESET      = 16'h0000;
endpackage
`default_nettype wire

// file: limit_reg_if.sv
`default_nettype none
interface limit_reg_if;
	logic        wrEn;
	logic [7:0]  wrAddr;
	logic [15:0] wrData;
	logic        windowLock;
	logic [15:0] upperLimit;
	logic [15:0] lowerLimit;
	logic [15:0] critLimit;

	modport bank (
		input  wrEn, wrAddr, wrData, windowLock,
		output upperLimit, lowerLimit, critLimit
	);
	modport core (
		output wrEn, wrAddr, wrData, windowLock,
		input  upperLimit, lowerLimit, critLimit
	);
endinterface
`default_nettype wire

// file: limit_reg_bank.sv
`default_nettype none
module limit_reg_bank (
	input  wire logic  ref_clk,
	input  wire logic  srst,
	limit_reg_if.bank  lim
);
	// ----------------------------------------
	// Limit registers
	// ----------------------------------------
	logic [15:0] upper_r;
	logic [15:0] lower_r;
	logic [15:0] crit_r;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			upper_r <= temp_limit_pkg::LIMIT_RESET; // [R14]
			lower_r <= temp_limit_pkg::LIMIT_RESET; // [R14]
		end else if (lim.wrEn && !lim.windowLock) begin // [R11]
			if (lim.wrAddr == temp_limit_pkg::PTR_UPPER) begin
				upper_r <= lim.wrData & temp_limit_pkg::LIMIT_MASK; // [R7]
			end
			if (lim.wrAddr == temp_limit_pkg::PTR_LOWER) begin
				lower_r <= lim.wrData & temp_limit_pkg::LIMIT_MASK; // [R8]
			end
		end
	end

	// Critical limit is not covered by the window lock, so it stays writable here
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			crit_r <= temp_limit_pkg::LIMIT_RESET;
		end else if (lim.wrEn && lim.wrAddr == temp_limit_pkg::PTR_CRIT) begin
			crit_r <= lim.wrData & temp_limit_pkg::LIMIT_MASK; // [R12]
		end
	end

	assign lim.upperLimit = upper_r;
	assign lim.lowerLimit = lower_r;
	assign lim.critLimit  = crit_r;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	AST_LOCK_UPPER: assert property (lim.windowLock && lim.wrEn |=> $stable(upper_r)) // [R11]
		else $error("upper limit changed while locked");
	AST_LOCK_LOWER: assert property (lim.windowLock && lim.wrEn |=> $stable(lower_r)) // [R11]
		else $error("lower limit changed while locked");
	AST_UPPER_RSVD: assert property ((upper_r & ~temp_limit_pkg::LIMIT_MASK) == 16'h0000) // [R7]
		else $error("upper limit reserved bits set");
	AST_LOWER_RSVD: assert property ((lower_r & ~temp_limit_pkg::LIMIT_MASK) == 16'h0000) // [R8]
		else $error("lower limit reserved bits set");
	AST_CRIT_WRITE: assert property (lim.wrEn && lim.wrAddr == temp_limit_pkg::PTR_CRIT // [R12]
		|=> crit_r == ($past(lim.wrData) & temp_limit_pkg::LIMIT_MASK))
		else $error("critical limit not stored as masked");
	AST_RESET_ZERO: assert property (@(posedge ref_clk) disable iff (1'b0) // [R14]
		srst |=> upper_r == 16'h0000 && lower_r == 16'h0000)
		else $error("window limits not cleared by reset");
endmodule // limit_reg_bank
`default_nettype wire

// file: host_model.sv
`default_nettype none
module host_model (
	input  wire logic        ref_clk,
	output logic      [7:0]  regAddr,
	output logic             regWrite,
	output logic      [15:0] regWdata,
	input  wire logic [15:0] regRdata
);
	timeunit 1ns;
	timeprecision 100ps;
	// No alert source here, so limits may change freely
	initial begin
		regAddr = 8'h00;
		regWrite = 1'b0;
		regWdata = 16'h0000;
	end
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge ref_clk);
		regAddr = a;
		regWrite = 1'b1;
		regWdata = d;
		@(negedge ref_clk);
		regWrite = 1'b0;
		// Released data shows its inverse, never a stale copy
		regWdata = ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(negedge ref_clk);
		regAddr = a;
		@(negedge ref_clk);
		d = regRdata;
	endtask
endmodule // host_model
`default_nettype wire

// file: temp_limit_compare_bench.sv
`default_nettype none
module temp_limit_compare_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic        ref_clk = 1'b0;
	logic        srst = 1'b1;
	logic        convValid = 1'b0;
	logic [11:0] convSample = 12'h000;
	logic [12:0] hystAmount = 13'h0000;
	logic [7:0]  regAddr;
	logic        regWrite;
	logic [15:0] regWdata, regRdata, tempWord, eTemp;
	logic        windowLock;
	logic [2:0]  ef;
	int          mismatches = 0, comparisons = 0, eu, el, ec;
	always #12.5 ref_clk = ~ref_clk;
	temp_limit_compare temp_limit_compare_i (.ref_clk(ref_clk), .srst(srst), .convValid(convValid),
		.convSample(convSample), .hystAmount(hystAmount), .regAddr(regAddr), .regWrite(regWrite),
		.regWdata(regWdata), .regRdata(regRdata), .tempWord(tempWord), .windowLock(windowLock));
	host_model host_model_i (.ref_clk(ref_clk), .regAddr(regAddr), .regWrite(regWrite),
		.regWdata(regWdata), .regRdata(regRdata));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic rdChk(input string what, input logic [7:0] a, input logic [15:0] exp);
		logic [15:0] v;
		host_model_i.rd(a, v);
		check(what, v, exp);
	endtask
	task automatic conv(input logic [11:0] s);
		int t, h;
		t = int'($signed(s)) * 2;
		h = int'(hystAmount);
		@(negedge ref_clk);
		convValid = 1'b1;
		convSample = s;
		// Reference flags: stored state picks the threshold
		ef[2] = ef[2] ? !(t < ec - h) : (t >= ec);
		ef[1] = ef[1] ? !(t <= eu - h) : (t > eu);
		ef[0] = ef[0] ? !(t >= el) : (t < el - h);
		eTemp = {ef, s, 1'b0};
		@(negedge ref_clk);
		convValid = 1'b0;
		check("tempWord", tempWord, eTemp);
	endtask
	task automatic doReset();
		srst = 1'b1;
		repeat (5) @(negedge ref_clk);
		srst = 1'b0;
		ef = 3'b000;
		{eu, el, ec} = {32'sd0, 32'sd0, 32'sd0};
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic testReset();
		check("windowLock", {15'h0000, windowLock}, 16'h0000);
		for (int i = 2; i <= 5; i++)
			rdChk("reset value", i[7:0], 16'h0000);
		$display("test reset done");
	endtask
	task automatic testFormat();
		logic [11:0] samples [6] = '{12'h0C8, 12'h3E8, 12'h001, 12'hFFF, 12'hF38, 12'h000};
		host_model_i.wr(temp_limit_pkg::PTR_UPPER, 16'h0FFC);
		host_model_i.wr(temp_limit_pkg::PTR_LOWER, 16'h1000);
		host_model_i.wr(temp_limit_pkg::PTR_CRIT, 16'h0FFC);
		{eu, el, ec} = {32'sd4092, -32'sd4096, 32'sd4092};
		foreach (samples[i]) begin
			conv(samples[i]);
			if (i == 1)
				check("tempWord 125C", tempWord, 16'h07D0);
		end
		$display("test format done");
	endtask
	task automatic testFlags();
		logic [11:0] samples [14] = '{12'h0A0, 12'h140, 12'h141, 12'h136, 12'h133, 12'h1E0, 12'h1DB,
			12'h1D3, 12'h04F, 12'h043, 12'h04F, 12'h050, 12'hFF0, 12'h0A0};
		host_model_i.wr(temp_limit_pkg::PTR_UPPER, 16'h0280);
		host_model_i.wr(temp_limit_pkg::PTR_LOWER, 16'h00A0);
		host_model_i.wr(temp_limit_pkg::PTR_CRIT, 16'h03C0);
		{eu, el, ec} = {32'sd640, 32'sd160, 32'sd960};
		hystAmount = 13'h0018;
		foreach (samples[i])
			conv(samples[i]);
		$display("test flags done");
	endtask
	task automatic testLimits();
		for (int i = 2; i <= 4; i++) begin
			host_model_i.wr(i[7:0], 16'hFFFF);
			rdChk("limit mask", i[7:0], 16'h1FFC);
		end
		host_model_i.wr(temp_limit_pkg::PTR_TEMP, 16'h1234);
		rdChk("temp word", temp_limit_pkg::PTR_TEMP, eTemp);
		rdChk("unmapped", 8'h7F, 16'h0000);
		host_model_i.wr(temp_limit_pkg::PTR_UPPER, 16'h0100);
		host_model_i.wr(temp_limit_pkg::PTR_LOWER, 16'h0000);
		host_model_i.wr(temp_limit_pkg::PTR_CRIT, 16'h0FFC);
		{eu, el, ec} = {32'sd256, 32'sd0, 32'sd4092};
		conv(12'h0A0);
		host_model_i.wr(temp_limit_pkg::PTR_UPPER, 16'h0280);
		eu = 640;
		conv(12'h0A0);
		// Result lands the cycle right after the write, so the new limit must already count
		eu = 256;
		fork
			host_model_i.wr(temp_limit_pkg::PTR_UPPER, 16'h0100);
			begin
				@(negedge ref_clk);
				conv(12'h0A0);
			end
		join
		$display("test limits done");
	endtask
	task automatic testLock();
		host_model_i.wr(temp_limit_pkg::PTR_CONFIG, 16'h0040);
		check("windowLock", {15'h0000, windowLock}, 16'h0001);
		rdChk("config", temp_limit_pkg::PTR_CONFIG, 16'h0040);
		host_model_i.wr(temp_limit_pkg::PTR_UPPER, 16'h0000);
		host_model_i.wr(temp_limit_pkg::PTR_LOWER, 16'h0100);
		host_model_i.wr(temp_limit_pkg::PTR_CRIT, 16'h0400);
		host_model_i.wr(temp_limit_pkg::PTR_CONFIG, 16'h0000);
		rdChk("locked upper", temp_limit_pkg::PTR_UPPER, 16'h0100);
		rdChk("locked lower", temp_limit_pkg::PTR_LOWER, 16'h0000);
		rdChk("crit", temp_limit_pkg::PTR_CRIT, 16'h0400);
		check("windowLock held", {15'h0000, windowLock}, 16'h0001);
		doReset();
		check("windowLock cleared", {15'h0000, windowLock}, 16'h0000);
		rdChk("upper after reset", temp_limit_pkg::PTR_UPPER, 16'h0000);
		$display("test lock done");
	endtask
	// ----------------------------------------
	// Sequence and watchdog
	// ----------------------------------------
	initial begin
		doReset();
		testReset();
		testFormat();
		testFlags();
		testLimits();
		testLock();
		results();
	end
	initial begin
		// About 125 cycles expected; allow sixteen times that
		#50000;
		mismatches++;
		results();
	end
endmodule // temp_limit_compare_bench
`default_nettype wire
